//--- bsem_pkg.sv
// Constants, types and helpers of the buffer status event mailbox
package bsem_pkg;
    localparam int NUM_PATHS = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // Register offsets
    localparam logic [3:0] OFF_HEADER = 4'h0;
    localparam logic [3:0] OFF_CTRL = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_ACK = 4'h3;
    localparam logic [3:0] OFF_LEN_BASE = 4'h4;
    localparam logic [3:0] OFF_ONLINE = 4'h8;
    localparam logic [3:0] OFF_STATREQ = 4'h9;

    // Field positions
    localparam int HDR_PATH_LSB = 6;
    localparam int HDR_CODE_LSB = 2;
    localparam int CTRL_FLAGS_LSB = 8;
    localparam int STATUS_FULL_BIT = 0;
    localparam int STATUS_INIT_BIT = 1;
    localparam int ACK_BIT = 0;
    localparam int SREQ_FORCE_BIT = 4;

    // Message codes
    localparam logic [3:0] CODE_PATH0 = 4'hF;
    localparam logic [3:0] CODE_PATHN = 4'hA;
    localparam logic [1:0] SRC_PATH0 = 2'h1;
    localparam logic [1:0] SRC_PATHN = 2'h0;
    localparam logic [7:0] EV_RX_OVF = 8'h1F;
    localparam logic [7:0] EV_TX_OVF = 8'h2F;
    localparam logic [3:0] INIT_FLAGS = 4'hF;
    localparam logic [7:0] GEN_HEADER = 8'h00;

    // Buffer cost of a message beyond its payload: header and control word
    localparam logic [16:0] MSG_OVERHEAD = 17'h00003;

    // Reset values
    localparam logic [15:0] MSG_LEN_RST = 16'h0000;
    localparam logic [3:0] ONLINE_RST = 4'h0;
    localparam logic [7:0] HEADER_RST = 8'h00;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_WAIT_INIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_FULL = 3'b100
    } bsem_state_t;

    // Locations one message of the given payload length takes
    function automatic logic [16:0] msg_cost(input logic [15:0] len);
        msg_cost = {1'b0, len} + MSG_OVERHEAD;
    endfunction : msg_cost

    // Header of a buffer specific event
    function automatic logic [7:0] spec_header(input logic [1:0] path);
        if (path == 2'h0) begin
            spec_header = {path, CODE_PATH0, SRC_PATH0};
        end else begin
            spec_header = {path, CODE_PATHN, SRC_PATHN};
        end
    endfunction : spec_header
endpackage : bsem_pkg

//--- bsem_room_track.sv
// Per-path write buffer room tracker raising buffer-available triggers
`timescale 1ns/10ps
`default_nettype none
module bsem_room_track (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Buffer state
    input wire logic [15:0] i_free,
    input wire logic [15:0] i_len,
    input wire logic i_online,
    input wire logic i_written,
    input wire logic i_force,
    // Trigger
    output var logic o_trig
);
    import bsem_pkg::*;

    logic room;
    logic room_r;
    logic room_nxt;
    logic trig_nxt;

    always_comb begin
        room = {1'b0, i_free} >= msg_cost(i_len);
        room_nxt = room;
        // Offline paths and full buffers never raise, so no stale request can appear
        trig_nxt = i_online & room & ((~room_r) | i_written | i_force);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            room_r <= 1'b0;
            o_trig <= 1'b0;
        end else begin
            room_r <= room_nxt;
            o_trig <= trig_nxt;
        end
    end

    room_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_online && !room_r && room) |=> o_trig) else $error("room rise not flagged");
    write_room_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_online && i_written && room) |=> o_trig) else $error("write with room not flagged");
    no_room_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_trig |-> $past(room) && $past(i_online)) else $error("trigger without room or offline");
    steady_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (room_r && !i_written && !i_force) |=> !o_trig) else $error("repeat without trigger");
endmodule : bsem_room_track
`default_nettype wire

//--- bsem_mailbox.sv
// Buffer status event mailbox: builds outgoing header and control word
//
// Operation
// - Each message costs its length plus three buffer locations.
// - Specific event code is 1111 for path 0, 1010 for paths 1 to 3.
// - One general buffer-available event for all buffers, header all zero.
// - General event flags sit in control bits 11..8; other control bits zero.
// - Flag a path only when online and its write buffer has room.
// - Raise general event when a buffer gains room for another message.
// - Raise general event when room remains right after a host write.
// - An unserviced request is not repeated without a new trigger.
// - Later events flag only freshly triggered buffers, never stale ones.
// - Host status request can produce an indication without a transition.
// - Force bit set produces indication for the named path's transmit buffer.
// - After initialization emit a general event with all four flags set.
// - Room left above message length after write gives immediate indication.
// - Room left below message length withholds indication until room returns.
`timescale 1ns/10ps
`default_nettype none
module bsem_mailbox (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [bsem_pkg::ADDR_W-1:0] i_addr,
    input wire logic [bsem_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output var logic [bsem_pkg::DATA_W-1:0] o_rdata,
    // Buffer control unit
    input wire logic i_init_done,
    input wire logic [bsem_pkg::NUM_PATHS-1:0] i_written,
    input wire logic [bsem_pkg::NUM_PATHS-1:0] i_rx_ovf,
    input wire logic [bsem_pkg::NUM_PATHS-1:0] i_tx_ovf,
    input wire logic [15:0] i_tx_free0,
    input wire logic [15:0] i_tx_free1,
    input wire logic [15:0] i_tx_free2,
    input wire logic [15:0] i_tx_free3,
    // Outgoing mailbox
    output var logic o_msg_ready,
    output var logic [7:0] o_header,
    output var logic [15:0] o_ctrl
);
    import bsem_pkg::*;

    // Lowest set path of a request vector
    function automatic logic [1:0] low_index(input logic [NUM_PATHS-1:0] v);
        low_index = 2'h0;
        for (int k = NUM_PATHS - 1; k >= 0; k--) begin
            if (v[k]) begin
                low_index = 2'(k);
            end
        end
    endfunction : low_index

    bsem_state_t state_r;
    bsem_state_t state_nxt;
    logic [7:0] hdr_r;
    logic [7:0] hdr_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [3:0] pend_r;
    logic [3:0] pend_nxt;
    logic [3:0] rxovf_r;
    logic [3:0] rxovf_nxt;
    logic [3:0] txovf_r;
    logic [3:0] txovf_nxt;
    logic [3:0] take_gen;
    logic [3:0] take_rx;
    logic [3:0] take_tx;
    logic [1:0] sel;
    logic [15:0] len_r [NUM_PATHS];
    logic [15:0] len_nxt [NUM_PATHS];
    logic [3:0] online_r;
    logic [3:0] online_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [3:0] force_vec;
    logic [3:0] trig_vec;
    logic ack_wr;
    logic [15:0] free_vec [NUM_PATHS];

    assign free_vec[0] = i_tx_free0;
    assign free_vec[1] = i_tx_free1;
    assign free_vec[2] = i_tx_free2;
    assign free_vec[3] = i_tx_free3;

    genvar g;
    generate
        for (g = 0; g < NUM_PATHS; g++) begin : g_track
            bsem_room_track u_track (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_free(free_vec[g]),
                .i_len(len_r[g]),
                .i_online(online_r[g]),
                .i_written(i_written[g]),
                .i_force(force_vec[g]),
                .o_trig(trig_vec[g])
            );
        end
    endgenerate

    // Register writes and reads
    always_comb begin
        online_nxt = online_r;
        for (int k = 0; k < NUM_PATHS; k++) begin
            len_nxt[k] = len_r[k];
        end
        force_vec = 4'h0;
        ack_wr = 1'b0;
        rdata_nxt = 16'h0000;
        if (i_wr) begin
            if (i_addr[3:2] == OFF_LEN_BASE[3:2]) begin
                len_nxt[i_addr[1:0]] = i_wdata;
            end
            if (i_addr == OFF_ONLINE) begin
                online_nxt = i_wdata[3:0];
            end
            if (i_addr == OFF_STATREQ && i_wdata[SREQ_FORCE_BIT]) begin
                force_vec[i_wdata[1:0]] = 1'b1;
            end
            if (i_addr == OFF_ACK) begin
                ack_wr = i_wdata[ACK_BIT];
            end
        end
        if (i_rd) begin
            if (i_addr[3:2] == OFF_LEN_BASE[3:2]) begin
                rdata_nxt = len_r[i_addr[1:0]];
            end else begin
                unique case (i_addr)
                    OFF_HEADER: rdata_nxt = {8'h00, hdr_r};
                    OFF_CTRL: rdata_nxt = ctrl_r;
                    OFF_STATUS: begin
                        rdata_nxt[STATUS_FULL_BIT] = state_r == ST_FULL;
                        rdata_nxt[STATUS_INIT_BIT] = state_r == ST_WAIT_INIT;
                    end
                    OFF_ONLINE: rdata_nxt = {12'h000, online_r};
                    default: rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            online_r <= ONLINE_RST;
            for (int k = 0; k < NUM_PATHS; k++) begin
                len_r[k] <= MSG_LEN_RST;
            end
            rdata_r <= 16'h0000;
        end else begin
            online_r <= online_nxt;
            for (int k = 0; k < NUM_PATHS; k++) begin
                len_r[k] <= len_nxt[k];
            end
            rdata_r <= rdata_nxt;
        end
    end

    // Mailbox loading; overflow events go first since they report lost data
    always_comb begin
        state_nxt = state_r;
        hdr_nxt = hdr_r;
        ctrl_nxt = ctrl_r;
        take_gen = 4'h0;
        take_rx = 4'h0;
        take_tx = 4'h0;
        sel = 2'h0;
        unique case (state_r)
            ST_WAIT_INIT: begin
                if (i_init_done) begin
                    hdr_nxt = GEN_HEADER;
                    ctrl_nxt = {4'h0, INIT_FLAGS, 8'h00};
                    state_nxt = ST_FULL;
                end
            end
            ST_IDLE: begin
                if (|rxovf_r) begin
                    sel = low_index(rxovf_r);
                    take_rx[sel] = 1'b1;
                    hdr_nxt = spec_header(sel);
                    ctrl_nxt = {EV_RX_OVF, 8'h00};
                    state_nxt = ST_FULL;
                end else if (|txovf_r) begin
                    sel = low_index(txovf_r);
                    take_tx[sel] = 1'b1;
                    hdr_nxt = spec_header(sel);
                    ctrl_nxt = {EV_TX_OVF, 8'h00};
                    state_nxt = ST_FULL;
                end else if (|pend_r) begin
                    take_gen = pend_r;
                    hdr_nxt = GEN_HEADER;
                    ctrl_nxt = {4'h0, pend_r, 8'h00};
                    state_nxt = ST_FULL;
                end
            end
            ST_FULL: begin
                if (ack_wr) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        // Sent flags are dropped at once, so stale paths never reappear; a new trigger wins
        pend_nxt = (pend_r & ~take_gen) | trig_vec;
        rxovf_nxt = (rxovf_r & ~take_rx) | i_rx_ovf;
        txovf_nxt = (txovf_r & ~take_tx) | i_tx_ovf;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= ST_WAIT_INIT;
            hdr_r <= HEADER_RST;
            ctrl_r <= CTRL_RST;
            pend_r <= 4'h0;
            rxovf_r <= 4'h0;
            txovf_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            hdr_r <= hdr_nxt;
            ctrl_r <= ctrl_nxt;
            pend_r <= pend_nxt;
            rxovf_r <= rxovf_nxt;
            txovf_r <= txovf_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_msg_ready = state_r[2];
    assign o_header = hdr_r;
    assign o_ctrl = ctrl_r;

    init_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_r == ST_WAIT_INIT && i_init_done) |=> (o_ctrl == 16'h0F00 && o_header == 8'h00 && o_msg_ready))
        else $error("initial event wrong");
    gen_header_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_r == ST_IDLE && rxovf_r == 4'h0 && txovf_r == 4'h0 && pend_r != 4'h0) |=> (o_header == 8'h00))
        else $error("general header not zero");
    gen_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_msg_ready && o_header == 8'h00) |-> (o_ctrl[15:12] == 4'h0 && o_ctrl[7:0] == 8'h00))
        else $error("general control bits not zero");
    path0_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_r == ST_IDLE && rxovf_r[0]) |=> (o_header == 8'h3D && o_ctrl == 16'h1F00))
        else $error("path 0 event code wrong");
    pathn_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_msg_ready && o_header[7:6] != 2'h0 && o_header != 8'h00) |-> (o_header[5:2] == 4'hA && o_ctrl[7:0] == 8'h00))
        else $error("path 1-3 event code wrong");
    fresh_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($rose(o_msg_ready) && $past(state_r) == ST_IDLE && o_header == 8'h00) |-> (o_ctrl[11:8] == $past(pend_r)))
        else $error("flags not the fresh triggers");
    no_repeat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!pend_r[1] && !trig_vec[1]) |=> !pend_r[1]) else $error("request repeated without trigger");
    force_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFF_STATREQ && i_wdata[4] && i_wdata[1:0] == 2'h2 && online_r[2] && trig_vec == 4'h0
         && {1'b0, i_tx_free2} >= msg_cost(len_r[2])) |=> ##1 pend_r[2])
        else $error("forced indication missing");
    read_lat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFF_CTRL) |=> (o_rdata == $past(ctrl_r))) else $error("control readback wrong");

    init_cov: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_msg_ready) && o_ctrl == 16'h0F00);
    gen_cov: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_msg_ready) && $past(state_r) == ST_IDLE && o_header == 8'h00);
    ovf_cov: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_msg_ready) && o_ctrl == 16'h2F00);
    multi_cov: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_msg_ready && o_ctrl[11:8] == 4'h6);
endmodule : bsem_mailbox
`default_nettype wire

//--- bsem_buf_model.sv
// Behavioural model of the per-path write buffers feeding the mailbox
`timescale 1ns/10ps
`default_nettype none
module bsem_buf_model #(
    parameter int BUF_SIZE = 64
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Bench command: 1 writes a message of i_cnt bytes, 2 drains i_cnt locations
    input wire logic [1:0] i_cmd,
    input wire logic [1:0] i_path,
    input wire logic [15:0] i_cnt,
    // Buffer state
    output var logic [3:0][15:0] o_free,
    output var logic [3:0] o_written
);
    always_ff @(posedge i_clk) begin
        o_written <= 4'h0;
        if (!i_rst_n) begin
            for (int p = 0; p < 4; p++)
                o_free[p] <= 16'(BUF_SIZE);
        end else if (i_cmd == 2'h1) begin
            // Header and control word are stored beside the payload
            o_free[i_path] <= o_free[i_path] - i_cnt - 16'h0003;
            o_written[i_path] <= 1'b1;
        end else if (i_cmd == 2'h2) begin
            o_free[i_path] <= o_free[i_path] + i_cnt;
        end
    end
endmodule : bsem_buf_model
`default_nettype wire

//--- buffer_status_event_mailbox_tb_top.sv
// Self-checking bench of the buffer status event mailbox
`timescale 1ns/10ps
`default_nettype none
module buffer_status_event_mailbox_tb_top;
    import bsem_pkg::*;
    localparam logic [15:0] LEN = 16'h0014;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_init_done = 1'b0;
    logic [3:0] i_rx_ovf = 4'h0;
    logic [3:0] i_tx_ovf = 4'h0;
    logic [1:0] cmd = 2'h0;
    logic [1:0] cpath = 2'h0;
    logic [15:0] ccnt = 16'h0000;
    logic [3:0][15:0] free;
    logic [3:0] written;
    logic [15:0] o_rdata;
    logic o_msg_ready;
    logic [7:0] o_header;
    logic [15:0] o_ctrl;
    int error_cnt = 0;
    int n_checks = 0;
    int fr [4] = '{64, 64, 64, 64};
    int p;
    int c;

    initial begin
        forever #25 i_clk = ~i_clk;
    end

    bsem_buf_model #(.BUF_SIZE(64)) model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_path(cpath),
        .i_cnt(ccnt), .o_free(free), .o_written(written));

    bsem_mailbox uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_init_done(i_init_done), .i_written(written), .i_rx_ovf(i_rx_ovf),
        .i_tx_ovf(i_tx_ovf), .i_tx_free0(free[0]), .i_tx_free1(free[1]), .i_tx_free2(free[2]),
        .i_tx_free3(free[3]), .o_msg_ready(o_msg_ready), .o_header(o_header), .o_ctrl(o_ctrl));

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_rdata, exp, "rdata");
    endtask : rd

    task automatic cyc(input logic [1:0] k, input int pth, input int n);
        @(posedge i_clk);
        cmd <= k;
        cpath <= 2'(pth);
        ccnt <= 16'(n);
        @(posedge i_clk);
        cmd <= 2'h0;
        if (k == 2'h1)
            fr[pth] -= n + 3;
        else
            fr[pth] += n;
    endtask : cyc

    task automatic no_msg(input int n);
        repeat (n) begin
            @(negedge i_clk);
            chk({15'h0000, o_msg_ready}, 16'h0000, "idle");
        end
    endtask : no_msg

    // Mailbox outputs are only looked at mid-cycle, never in the edge that loads them
    task automatic wait_msg(input logic [7:0] h, input logic [15:0] d);
        int i;
        @(negedge i_clk);
        for (i = 0; i < 20 && o_msg_ready !== 1'b1; i++)
            @(negedge i_clk);
        if (i == 20) begin
            error_cnt++;
            $display("wrong value at %0t: no message", $time);
            conclude();
        end else begin
            chk({8'h00, o_header}, {8'h00, h}, "header");
            chk(o_ctrl, d, "ctrl");
            rd(OFF_STATUS, 16'h0001);
            rd(OFF_CTRL, d);
            rd(OFF_HEADER, {8'h00, h});
            wr(OFF_ACK, 16'h0001);
            @(negedge i_clk);
            chk({15'h0000, o_msg_ready}, 16'h0000, "released");
        end
    endtask : wait_msg

    function automatic logic [7:0] exp_hdr(input int pth);
        return (pth == 0) ? 8'h3D : {2'(pth), 4'hA, 2'h0};
    endfunction : exp_hdr

    initial begin
        void'($urandom(91540));
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk(o_ctrl, 16'h0000, "reset ctrl");
        rd(OFF_STATUS, 16'h0002);
        no_msg(4);
        @(posedge i_clk);
        i_init_done <= 1'b1;
        wait_msg(8'h00, 16'h0F00);
        for (p = 0; p < 4; p++) begin
            c = $urandom;
            wr(OFF_LEN_BASE + 4'(p), 16'(c));
            rd(OFF_LEN_BASE + 4'(p), 16'(c));
            wr(OFF_LEN_BASE + 4'(p), LEN);
        end
        rd(4'hF, 16'h0000);
        rd(OFF_ACK, 16'h0000);
        // Path 3 loses its room while still offline
        cyc(2'h1, 3, 40);
        no_msg(8);
        wr(OFF_ONLINE, 16'h000F);
        rd(OFF_ONLINE, 16'h000F);
        // Going online is no room transition; paths 0 to 2 already had room and path 3 has none
        no_msg(8);
        wr(OFF_STATREQ, 16'h0010);
        wr(OFF_STATREQ, 16'h0011);
        wr(OFF_STATREQ, 16'h0012);
        wait_msg(8'h00, 16'h0100);
        wait_msg(8'h00, 16'h0600);
        cyc(2'h2, 3, 2);
        wait_msg(8'h00, 16'h0800);
        cyc(2'h1, 1, 5);
        wait_msg(8'h00, 16'h0200);
        cyc(2'h1, 1, 30);
        wait_msg(8'h00, 16'h0200);
        cyc(2'h1, 1, 0);
        no_msg(8);
        cyc(2'h2, 1, 3);
        wait_msg(8'h00, 16'h0200);
        cyc(2'h1, 2, 0);
        wait_msg(8'h00, 16'h0400);
        no_msg(8);
        cyc(2'h1, 0, 0);
        wait_msg(8'h00, 16'h0100);
        wr(OFF_STATREQ, 16'h0003);
        no_msg(8);
        wr(OFF_STATREQ, 16'h0013);
        wr(OFF_STATREQ, 16'h0012);
        wait_msg(8'h00, 16'h0800);
        wait_msg(8'h00, 16'h0400);
        for (p = 0; p < 4; p++) begin
            @(posedge i_clk);
            i_rx_ovf <= 4'h1 << p;
            @(posedge i_clk);
            i_rx_ovf <= 4'h0;
            wait_msg(exp_hdr(p), 16'h1F00);
            @(posedge i_clk);
            i_tx_ovf <= 4'h1 << p;
            @(posedge i_clk);
            i_tx_ovf <= 4'h0;
            wait_msg(exp_hdr(p), 16'h2F00);
        end
        // Random writes, each undone by a drain so the buffers never run dry
        repeat (24) begin
            p = $urandom % 4;
            c = $urandom % (fr[p] - 2);
            cyc(2'h1, p, c);
            if (fr[p] >= 23) begin
                wait_msg(8'h00, 16'h0100 << p);
                cyc(2'h2, p, c + 3);
                no_msg(6);
            end else begin
                no_msg(6);
                cyc(2'h2, p, c + 3);
                wait_msg(8'h00, 16'h0100 << p);
            end
        end
        conclude();
    end
endmodule : buffer_status_event_mailbox_tb_top
`default_nettype wire
